// ---- core/gpd_consts.svh ----
// register offsets, field positions, reset values and timing counts of the port pair
`ifndef GPD_CONSTS_SVH
`define GPD_CONSTS_SVH

// ----------------------------------------------------------------
// i/o space offsets
// ----------------------------------------------------------------
`define GPD_OFS_B_LEVELS   6'h16
`define GPD_OFS_B_DIR      6'h17
`define GPD_OFS_B_LATCH    6'h18
`define GPD_OFS_A_LEVELS   6'h19
`define GPD_OFS_A_DIR      6'h1A
`define GPD_OFS_A_LATCH    6'h1B
`define GPD_OFS_CORE_CTRL  6'h35

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GPD_EXT_MEM_EN_BIT 7
`define GPD_RST_LATCH      8'h00
`define GPD_RST_DIR        8'h00
`define GPD_RST_CTRL       8'h00

// ----------------------------------------------------------------
// external memory map and timing
// ----------------------------------------------------------------
`define GPD_EXT_BOUNDARY   16'h0460
`define GPD_STROBE_CYC     3'h4

`endif

// ---- core/gpd_pkg.sv ----
// types shared by the port pair design
`default_nettype none

package gpd_pkg;
	typedef enum logic [2:0] {
		XM_IDLE,
		XM_ADDR,
		XM_HOLD,
		XM_STROBE,
		XM_DONE
	} gpd_xm_state_t;
endpackage

`default_nettype wire

// ---- core/gpd_sync2.sv ----
// two-flop synchroniser for a byte of pin levels
`timescale 1ns/1ps
`default_nettype none

module gpd_sync2 (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pinIn,
	output logic      [7:0] levels
);
	logic [7:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		meta_reg <= pinIn;
		levels   <= meta_reg;
	end
endmodule

`default_nettype wire

// ---- core/gpd_gpio_port.sv ----
// one 8-bit port: output latch, direction, pin drive and pull-up control
`timescale 1ns/1ps
`default_nettype none
`include "gpd_consts.svh"

module gpd_gpio_port (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       wrLatch,
	input  wire logic       wrDir,
	input  wire logic [7:0] wrMask,
	input  wire logic [7:0] wrVal,
	input  wire logic [7:0] ovrEn,
	input  wire logic [7:0] ovrOe,
	input  wire logic [7:0] ovrOut,
	input  wire logic [7:0] ovrPu,
	input  wire logic [7:0] altSel,
	input  wire logic [7:0] altVal,
	output logic      [7:0] latchVal,
	output logic      [7:0] dirVal,
	output logic      [7:0] pinOut,
	output logic      [7:0] pinOe,
	output logic      [7:0] pinPu
);
	logic [7:0] oe_reg;
	logic [7:0] pu_reg;

	// ----------------------------------------------------------------
	// latch and direction, masked so one bit can change alone
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latchVal <= `GPD_RST_LATCH;
		end else if (wrLatch) begin
			latchVal <= (latchVal & ~wrMask) | (wrVal & wrMask);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dirVal <= `GPD_RST_DIR;
		end else if (wrDir) begin
			dirVal <= (dirVal & ~wrMask) | (wrVal & wrMask);
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			oe_reg <= 8'h00;
			pu_reg <= 8'h00;
			pinOut <= 8'h00;
		end else begin
			oe_reg <= (ovrEn & ovrOe) | (~ovrEn & dirVal);
			pu_reg <= (ovrEn & ovrPu) | (~ovrEn & ~dirVal & latchVal);
			pinOut <= (ovrEn & ovrOut) | (~ovrEn & altSel & altVal)
				| (~ovrEn & ~altSel & latchVal);
		end
	end

	// reset floats the pins at once; the gate keeps this off the clock
	assign pinOe = oe_reg & {8{~rst}};
	assign pinPu = pu_reg & {8{~rst}};
endmodule

`default_nettype wire

// ---- core/gpd_port_pair.sv ----
// two i/o ports with the external memory bus override of the first port
`timescale 1ns/1ps
`default_nettype none
`include "gpd_consts.svh"

module gpd_port_pair import gpd_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [5:0]  ioAddr,
	input  wire logic        ioWrEn,
	input  wire logic        ioRdEn,
	input  wire logic        ioSetBit,
	input  wire logic        ioClrBit,
	input  wire logic [2:0]  ioBitIdx,
	input  wire logic [7:0]  ioWrData,
	output logic      [7:0]  ioRdData,
	input  wire logic        xmReq,
	input  wire logic        xmWe,
	input  wire logic [15:0] xmAddr,
	input  wire logic [7:0]  xmWrData,
	output logic             xmAck,
	output logic      [7:0]  xmRdData,
	input  wire logic [7:0]  portAIn,
	output logic      [7:0]  portAOut,
	output logic      [7:0]  portAOe,
	output logic      [7:0]  portAPu,
	input  wire logic [7:0]  portBIn,
	output logic      [7:0]  portBOut,
	output logic      [7:0]  portBOe,
	output logic      [7:0]  portBPu,
	output logic      [7:0]  portCAddrOut,
	output logic             portCOvr,
	output logic             aleOut,
	output logic             rdStrobeN,
	output logic             wrStrobeN,
	output logic             portDEOvr,
	input  wire logic        timer0CompareOut,
	input  wire logic        timer0CompareEn,
	input  wire logic        timer2CompareOut,
	input  wire logic        timer2CompareEn,
	input  wire logic        uartSecondTx,
	input  wire logic        uartSecondTxEn,
	input  wire logic        spiMosiOut,
	input  wire logic        spiMisoOut,
	input  wire logic        spiSckOut,
	input  wire logic        spiOutEn,
	output logic             timer0CountIn,
	output logic             timer1CountIn,
	output logic             uartSecondRx,
	output logic             spiSsIn,
	output logic             spiMosiIn,
	output logic             spiMisoIn,
	output logic             spiSckIn
);
	logic [7:0]    core_control_reg;
	logic          extMemEn;
	gpd_xm_state_t state_reg;
	gpd_xm_state_t state_next;
	logic [2:0]    cnt_reg;
	logic [15:0]   addr_reg;
	logic [7:0]    wdata_reg;
	logic          we_reg;
	logic [7:0]    levelsA;
	logic [7:0]    levelsB;
	logic [7:0]    latchA;
	logic [7:0]    latchB;
	logic [7:0]    dirA;
	logic [7:0]    dirB;
	logic          anyWr;
	logic [7:0]    wrMask;
	logic [7:0]    wrVal;
	logic          isExt;
	logic          strobeLast;
	logic [7:0]    ovrOeA;
	logic [7:0]    ovrOutA;
	logic [7:0]    altSelB;
	logic [7:0]    altValB;

	assign extMemEn = core_control_reg[`GPD_EXT_MEM_EN_BIT];

	// ----------------------------------------------------------------
	// i/o space writes: whole byte or one bit
	// ----------------------------------------------------------------
	always_comb begin
		anyWr = ioWrEn | ioSetBit | ioClrBit;
		if (ioWrEn) begin
			wrMask = 8'hFF;
			wrVal  = ioWrData;
		end else begin
			wrMask = 8'(8'h01 << ioBitIdx);
			wrVal  = ioSetBit ? 8'hFF : 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_control_reg <= `GPD_RST_CTRL;
		end else if (anyWr && ioAddr == `GPD_OFS_CORE_CTRL) begin
			core_control_reg <= (core_control_reg & ~wrMask) | (wrVal & wrMask);
		end
	end

	// ----------------------------------------------------------------
	// i/o space reads, one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ioRdData <= 8'h00;
		end else if (ioRdEn) begin
			unique case (ioAddr)
				`GPD_OFS_A_LATCH:   ioRdData <= latchA;
				`GPD_OFS_A_DIR:     ioRdData <= dirA;
				`GPD_OFS_A_LEVELS:  ioRdData <= levelsA;
				`GPD_OFS_B_LATCH:   ioRdData <= latchB;
				`GPD_OFS_B_DIR:     ioRdData <= dirB;
				`GPD_OFS_B_LEVELS:  ioRdData <= levelsB;
				`GPD_OFS_CORE_CTRL: ioRdData <= core_control_reg;
				default:            ioRdData <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	gpd_sync2 u_sync_a (
		.ref_clk (ref_clk),
		.pinIn   (portAIn),
		.levels  (levelsA)
	);

	gpd_sync2 u_sync_b (
		.ref_clk (ref_clk),
		.pinIn   (portBIn),
		.levels  (levelsB)
	);

	// ----------------------------------------------------------------
	// external bus sequencer
	// ----------------------------------------------------------------
	// accesses below the boundary are internal and raise no ale or strobe, but their high address byte still reaches portCAddrOut
	assign isExt      = extMemEn && (xmAddr >= `GPD_EXT_BOUNDARY);
	assign strobeLast = (cnt_reg == `GPD_STROBE_CYC - 3'h1);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			XM_IDLE:   if (xmReq && isExt) state_next = XM_ADDR;
			XM_ADDR:   state_next = XM_HOLD;
			XM_HOLD:   state_next = XM_STROBE;
			XM_STROBE: if (strobeLast) state_next = XM_DONE;
			XM_DONE:   state_next = XM_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= XM_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || state_reg != XM_STROBE) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_reg  <= 16'h0000;
			wdata_reg <= 8'h00;
			we_reg    <= 1'b0;
		end else if (state_reg == XM_IDLE && xmReq) begin
			addr_reg  <= xmAddr;
			wdata_reg <= xmWrData;
			we_reg    <= xmWe;
		end
	end

	// answer: internal or disabled-range requests get zero, no aliasing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			xmAck    <= 1'b0;
			xmRdData <= 8'h00;
		end else begin
			xmAck <= (state_reg == XM_IDLE && xmReq && !isExt) || state_reg == XM_DONE;
			if (state_reg == XM_IDLE && xmReq && !isExt) begin
				xmRdData <= 8'h00;
			end else if (state_reg == XM_STROBE && strobeLast && !we_reg) begin
				xmRdData <= levelsA;
			end
		end
	end

	// port a drives the low address until the strobe phase; reads float it
	always_comb begin
		ovrOeA  = 8'h00;
		ovrOutA = addr_reg[7:0];
		unique case (state_reg)
			XM_ADDR, XM_HOLD: ovrOeA = 8'hFF;
			XM_STROBE, XM_DONE: begin
				ovrOeA  = we_reg ? 8'hFF : 8'h00;
				ovrOutA = wdata_reg;
			end
			XM_IDLE: ovrOeA = 8'h00;
		endcase
	end

	// control pins share the one-cycle register stage of the port pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aleOut       <= 1'b0;
			rdStrobeN    <= 1'b1;
			wrStrobeN    <= 1'b1;
			portCAddrOut <= 8'h00;
			portCOvr     <= 1'b0;
			portDEOvr    <= 1'b0;
		end else begin
			aleOut       <= (state_reg == XM_ADDR);
			rdStrobeN    <= !(state_reg == XM_STROBE && !we_reg);
			wrStrobeN    <= !(state_reg == XM_STROBE && we_reg);
			portCAddrOut <= addr_reg[15:8];
			portCOvr     <= extMemEn;
			portDEOvr    <= extMemEn;
		end
	end

	// ----------------------------------------------------------------
	// ports
	// ----------------------------------------------------------------
	gpd_gpio_port u_port_a (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wrLatch  (anyWr && ioAddr == `GPD_OFS_A_LATCH),
		.wrDir    (anyWr && ioAddr == `GPD_OFS_A_DIR),
		.wrMask   (wrMask),
		.wrVal    (wrVal),
		.ovrEn    ({8{extMemEn}}),
		.ovrOe    (ovrOeA),
		.ovrOut   (ovrOutA),
		.ovrPu    (8'hFF),
		.altSel   (8'h00),
		.altVal   (8'h00),
		.latchVal (latchA),
		.dirVal   (dirA),
		.pinOut   (portAOut),
		.pinOe    (portAOe),
		.pinPu    (portAPu)
	);

	// peripheral outputs replace the latch value only; direction stays
	// with software, as the alternate functions expect
	always_comb begin
		altSelB = {spiOutEn, spiOutEn, spiOutEn, 1'b0, uartSecondTxEn, 1'b0,
			timer2CompareEn, timer0CompareEn};
		altValB = {spiSckOut, spiMisoOut, spiMosiOut, 1'b0, uartSecondTx, 1'b0,
			timer2CompareOut, timer0CompareOut};
	end

	gpd_gpio_port u_port_b (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wrLatch  (anyWr && ioAddr == `GPD_OFS_B_LATCH),
		.wrDir    (anyWr && ioAddr == `GPD_OFS_B_DIR),
		.wrMask   (wrMask),
		.wrVal    (wrVal),
		.ovrEn    (8'h00),
		.ovrOe    (8'h00),
		.ovrOut   (8'h00),
		.ovrPu    (8'h00),
		.altSel   (altSelB),
		.altVal   (altValB),
		.latchVal (latchB),
		.dirVal   (dirB),
		.pinOut   (portBOut),
		.pinOe    (portBOe),
		.pinPu    (portBPu)
	);

	always_ff @(posedge ref_clk) begin
		timer0CountIn <= levelsB[0];
		timer1CountIn <= levelsB[1];
		uartSecondRx  <= levelsB[2];
		spiSsIn       <= levelsB[4];
		spiMosiIn     <= levelsB[5];
		spiMisoIn     <= levelsB[6];
		spiSckIn      <= levelsB[7];
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_bit_set_isolated: assert property (@(posedge ref_clk) disable iff (rst)
		(ioSetBit && !ioWrEn && ioAddr == `GPD_OFS_B_DIR) |=>
		(dirB == ($past(dirB) | 8'($past(8'h01 << ioBitIdx)))))
		else $error("single bit set disturbed other direction bits");

	a_latch_readback: assert property (@(posedge ref_clk) disable iff (rst)
		(ioRdEn && ioAddr == `GPD_OFS_A_LATCH && !anyWr) |=> (ioRdData == latchA))
		else $error("latch read does not return stored bits");

	a_levels_lag: assert property (@(posedge ref_clk) disable iff (rst)
		##2 (levelsB == $past(portBIn, 2)))
		else $error("pin levels not two cycles behind pins");

	a_gpio_drive: assert property (@(posedge ref_clk) disable iff (rst)
		(!extMemEn && !$past(extMemEn)) |=> (portBOe == $past(dirB)))
		else $error("port b enable does not follow direction");

	a_pullup_gate: assert property (@(posedge ref_clk) disable iff (rst)
		##1 ((portBPu & portBOe) == 8'h00))
		else $error("pull-up on while pin drives");

	a_reset_float: assert property (@(posedge ref_clk)
		rst |-> (portAOe == 8'h00 && portBOe == 8'h00))
		else $error("pins driven during reset");

	a_bus_pullups: assert property (@(posedge ref_clk) disable iff (rst)
		$past(extMemEn) |-> (portAPu == 8'hFF))
		else $error("port a pull-ups off as bus");

	a_ale_then_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(aleOut) |-> (portAOe == 8'hFF && portAOut == $past(addr_reg[7:0], 2))
		##1 (!rdStrobeN || !wrStrobeN) [*4] ##1 (rdStrobeN && wrStrobeN))
		else $error("address or strobe timing wrong");

	a_ale_low_transfer: assert property (@(posedge ref_clk) disable iff (rst)
		(!rdStrobeN || !wrStrobeN) |-> !aleOut)
		else $error("address strobe high during transfer");

	a_no_ext_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		(state_reg == XM_IDLE && xmReq && !isExt) |=> xmAck ##1 (rdStrobeN && wrStrobeN))
		else $error("internal access reached external strobes");
endmodule

`default_nettype wire

// ---- sim/gpd_sram_model.sv ----
// external sram behind a transparent address latch on port a and port c
`timescale 1ns/1ps
`default_nettype none

module gpd_sram_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] busIn,
	input  wire logic [7:0] busOut,
	input  wire logic [7:0] hiAddr,
	input  wire logic       aleOut,
	input  wire logic       rdStrobeN,
	input  wire logic       wrStrobeN,
	output logic      [7:0] memData,
	output logic            memDrive
);
	logic [7:0] loAddr;
	logic [7:0] mem [bit [15:0]];

	// transparent while the strobe is high, so the falling edge freezes the address
	always_latch begin
		if (aleOut) begin
			loAddr = busOut;
		end
	end

	always @(posedge ref_clk) begin
		if (!wrStrobeN) begin
			mem[{hiAddr, loAddr}] = busIn;
		end
	end

	// an unwritten word reads as the inverse of the last driven byte, never as a
	// lucky match; the pin level itself would loop back through the bus
	assign memDrive = !rdStrobeN;
	always_comb begin
		memData = mem.exists({hiAddr, loAddr}) ? mem[{hiAddr, loAddr}] : ~busOut;
	end
endmodule

`default_nettype wire

// ---- sim/gpd_port_pair_bench.sv ----
// self-checking bench for the port pair with an external sram partner
`timescale 1ns/1ps
`default_nettype none
`include "gpd_consts.svh"

module gpd_port_pair_bench;
	localparam logic [3:0] WR = 4'h8, SET = 4'h4, CLR = 4'h2, RD = 4'h1;
	logic        ref_clk, rst, ioWrEn, ioRdEn, ioSetBit, ioClrBit, xmReq, xmWe, xmAck;
	logic [5:0]  ioAddr;
	logic [2:0]  ioBitIdx;
	logic [15:0] xmAddr;
	logic [7:0]  ioWrData, ioRdData, xmWrData, xmRdData, first_port_levels, port_b_pin_levels, extA, extB;
	logic [7:0]  portAOut, portAOe, portAPu, portBOut, portBOe, portBPu, portCAddrOut;
	logic [7:0]  memData, altEn, altOut;
	logic        portCOvr, aleOut, rdStrobeN, wrStrobeN, portDEOvr, memDrive;
	logic [6:0]  altIn;
	int          bad_count, num_checks;

	assign first_port_levels = (portAOe & portAOut) | (~portAOe & (memDrive ? memData : (portAPu | extA)));
	assign port_b_pin_levels = (portBOe & portBOut) | (~portBOe & (portBPu | extB));

	gpd_port_pair dut (.ref_clk(ref_clk), .rst(rst), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
		.ioRdEn(ioRdEn), .ioSetBit(ioSetBit), .ioClrBit(ioClrBit), .ioBitIdx(ioBitIdx),
		.ioWrData(ioWrData), .ioRdData(ioRdData), .xmReq(xmReq), .xmWe(xmWe),
		.xmAddr(xmAddr), .xmWrData(xmWrData), .xmAck(xmAck), .xmRdData(xmRdData),
		.portAIn(first_port_levels), .portAOut(portAOut), .portAOe(portAOe), .portAPu(portAPu),
		.portBIn(port_b_pin_levels), .portBOut(portBOut), .portBOe(portBOe), .portBPu(portBPu),
		.portCAddrOut(portCAddrOut), .portCOvr(portCOvr), .aleOut(aleOut),
		.rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .portDEOvr(portDEOvr),
		.timer0CompareOut(altOut[0]), .timer0CompareEn(altEn[0]),
		.timer2CompareOut(altOut[1]), .timer2CompareEn(altEn[1]),
		.uartSecondTx(altOut[3]), .uartSecondTxEn(altEn[3]), .spiMosiOut(altOut[5]),
		.spiMisoOut(altOut[6]), .spiSckOut(altOut[7]), .spiOutEn(altEn[5]),
		.timer0CountIn(altIn[0]), .timer1CountIn(altIn[1]), .uartSecondRx(altIn[2]),
		.spiSsIn(altIn[3]), .spiMosiIn(altIn[4]), .spiMisoIn(altIn[5]), .spiSckIn(altIn[6]));

	gpd_sram_model sram (.ref_clk(ref_clk), .busIn(first_port_levels), .busOut(portAOut),
		.hiAddr(portCAddrOut), .aleOut(aleOut), .rdStrobeN(rdStrobeN),
		.wrStrobeN(wrStrobeN), .memData(memData), .memDrive(memDrive));

	// ----------------------------------------------------------------
	// shared bus cycles and comparison
	// ----------------------------------------------------------------
	task automatic cyc(int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle strobe, then one idle cycle so the effect or read data has landed
	task automatic io(logic [3:0] op, logic [5:0] a, logic [7:0] d);
		{ioWrEn, ioSetBit, ioClrBit, ioRdEn} = op;
		ioAddr = a;
		ioWrData = d;
		ioBitIdx = d[2:0];
		cyc();
		{ioWrEn, ioSetBit, ioClrBit, ioRdEn} = 4'h0;
		cyc();
	endtask

	task automatic rd(logic [5:0] a, logic [7:0] exp, string what);
		io(RD, a, 8'h00);
		chk(what, exp, ioRdData);
	endtask

	task automatic xm(logic we, logic [15:0] a, logic [7:0] d, bit ext);
		int n, low, rises;
		logic aleQ;
		{xmReq, xmWe, xmAddr, xmWrData} = {1'b1, we, a, d};
		cyc();
		xmReq = 0;
		{n, low, rises, aleQ} = {32'd0, 32'd0, 32'd0, aleOut};
		while (!xmAck && n < 12) begin
			cyc();
			n++;
			if (ext && n == 1) begin
				chk("addr lo", a[7:0], portAOut);
				chk("addr hi", a[15:8], portCAddrOut);
				chk("bus oe", 8'hFF, portAOe);
				chk("ale high", 1, aleOut);
			end
			if (ext && n == 2) chk("addr held", a[7:0], portAOut);
			if (!rdStrobeN || !wrStrobeN) begin
				low++;
				chk("ale low", 0, aleOut);
				chk("other strobe", 1, we ? rdStrobeN : wrStrobeN);
				if (!we) chk("bus pullup", 8'hFF, portAPu);
			end
			rises += int'(aleOut && !aleQ);
			aleQ = aleOut;
		end
		// ack is seen just after the edge that sets it; the +1 counts the request edge before the loop
		chk("ack cycle", ext ? 16'h0008 : 16'h0001, 16'(n + 1));
		chk("strobe cycles", ext ? `GPD_STROBE_CYC : 0, low);
		if (ext) chk("ale pulses", 1, rises);
		// let the ack cycle pass so the next request is not raised in this step
		cyc();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		io(WR, `GPD_OFS_A_LEVELS, 8'hFF);
		io(WR, `GPD_OFS_B_LEVELS, 8'hFF);
		rd(`GPD_OFS_A_DIR, 8'h00, "dir a");
		rd(`GPD_OFS_A_LATCH, 8'h00, "latch a");
		rd(`GPD_OFS_B_DIR, 8'h00, "dir b");
		rd(`GPD_OFS_B_LATCH, 8'h00, "latch b");
		rd(6'h00, 8'h00, "unmapped");
		$display("test regs done");
	endtask

	task automatic t_rmw();
		io(WR, `GPD_OFS_A_LATCH, 8'hA5);
		io(SET, `GPD_OFS_A_LATCH, 8'h01);
		io(CLR, `GPD_OFS_A_LATCH, 8'h00);
		rd(`GPD_OFS_A_LATCH, 8'hA6, "latch a bits");
		io(WR, `GPD_OFS_B_DIR, 8'hF0);
		io(SET, `GPD_OFS_B_DIR, 8'h02);
		io(CLR, `GPD_OFS_B_DIR, 8'h07);
		rd(`GPD_OFS_B_DIR, 8'h74, "dir b bits");
		$display("test rmw done");
	endtask

	task automatic t_pins();
		io(WR, `GPD_OFS_A_DIR, 8'h0F);
		io(WR, `GPD_OFS_A_LATCH, 8'h3C);
		cyc(4);
		chk("oe a", 8'h0F, portAOe);
		chk("out a", 8'h0C, portAOut & 8'h0F);
		chk("pullup a", 8'h30, portAPu);
		rd(`GPD_OFS_A_LEVELS, 8'h7C, "levels a");
		$display("test pins done");
	endtask

	task automatic t_alt();
		io(WR, `GPD_OFS_B_DIR, 8'hFF);
		io(WR, `GPD_OFS_B_LATCH, 8'h00);
		{altEn, altOut} = {8'hEB, 8'hFF};
		cyc(3);
		chk("alt out b", 8'hEB, portBOut);
		io(WR, `GPD_OFS_B_DIR, 8'h00);
		cyc(4);
		chk("alt in b", {extB[7:4], extB[2:0]}, altIn);
		rd(`GPD_OFS_B_LEVELS, extB, "levels b");
		$display("test alt done");
	endtask

	task automatic t_xm();
		xm(1'b1, 16'h1000, 8'h5C, 0);
		io(WR, `GPD_OFS_CORE_CTRL, 8'h80);
		cyc(2);
		chk("bus ovr", 2'b11, {portCOvr, portDEOvr});
		xm(1'b1, 16'h1234, 8'h5C, 1);
		chk("sram word", 8'h5C, sram.mem[16'h1234]);
		xm(1'b0, 16'h0100, 8'h00, 0);
		xm(1'b0, 16'h1234, 8'h00, 1);
		chk("read back", 8'h5C, xmRdData);
		io(WR, `GPD_OFS_CORE_CTRL, 8'h00);
		cyc(2);
		chk("normal oe", 8'h0F, portAOe);
		// a word that sits in the external sram must not come back when disabled
		xm(1'b0, 16'h1234, 8'h00, 0);
		chk("no alias", 8'h00, xmRdData);
		$display("test xm done");
	endtask

	task automatic t_reset();
		io(WR, `GPD_OFS_A_DIR, 8'hF0);
		cyc(2);
		rst = 1;
		#1;
		chk("oe at reset", 16'h0000, {portAOe, portBOe});
		chk("pu at reset", 16'h0000, {portAPu, portBPu});
		cyc();
		rst = 0;
		rd(`GPD_OFS_A_DIR, 8'h00, "dir after reset");
		$display("test reset done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		{rst, ioWrEn, ioRdEn, ioSetBit, ioClrBit, xmReq, xmWe} = 7'h40;
		{ioAddr, ioBitIdx, ioWrData, xmAddr, xmWrData} = '0;
		{extA, extB, altEn, altOut} = {8'h5A, 8'hB6, 8'h00, 8'h00};
		cyc(20);
		rst = 0;
		t_regs();
		t_rmw();
		t_pins();
		t_alt();
		t_xm();
		t_reset();
		end_sim();
	end

	// the scenarios need well under a thousand cycles
	initial begin
		repeat (4000) @(posedge ref_clk);
		bad_count++;
		end_sim();
	end
endmodule

`default_nettype wire
